// *** rtl/sfcc_defs.vh ***
/*
 * Constants for the motor filter current compensation block: register
 * offsets, field positions, reset values and fixed-point scaling.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef SFCC_DEFS_VH
`define SFCC_DEFS_VH

// ****************************************************************
// Register offsets (byte addresses, one word each)
// ****************************************************************
`define SFCC_OFS_CTRL       8'h00
`define SFCC_OFS_FREQ       8'h04
`define SFCC_OFS_IDREF      8'h08
`define SFCC_OFS_IQREF      8'h0C
`define SFCC_OFS_LS         8'h10
`define SFCC_OFS_FLUX       8'h14
`define SFCC_OFS_CFILT      8'h18
`define SFCC_OFS_LFILT      8'h1C
`define SFCC_OFS_STATUS     8'h20
`define SFCC_OFS_UD         8'h24
`define SFCC_OFS_UQ         8'h28
`define SFCC_OFS_ICD        8'h2C
`define SFCC_OFS_ICQ        8'h30
`define SFCC_OFS_IDOUT      8'h34
`define SFCC_OFS_IQOUT      8'h38
`define SFCC_OFS_SAMPLES    8'h3C

// ****************************************************************
// Fields
// ****************************************************************
`define SFCC_CTRL_SEL_LSB   0
`define SFCC_CTRL_SEL_MSB   1
`define SFCC_STAT_DECOUP    2
`define SFCC_STAT_BUSY      3

// ****************************************************************
// Filter selector codes
// ****************************************************************
`define SFCC_SEL_OFF        2'h0
`define SFCC_SEL_CHOKE      2'h1
`define SFCC_SEL_SINE       2'h2

// ****************************************************************
// Reset values
// ****************************************************************
`define SFCC_RST_SEL        2'h0
`define SFCC_RST_WORD       32'h00000000

// ****************************************************************
// Fixed-point: 2*pi in Q3.13, per-phase factor, product shift
// ****************************************************************
`define SFCC_TWO_PI_Q13     16'hC910
`define SFCC_DELTA_FACTOR   18'h00003
`define SFCC_FRAC_BITS      13

`endif

// *** rtl/sfcc_mul.v ***
/*
 * Signed fixed-point multiplier, registered output, scaled by FRAC bits.
 * Assumes operands are stable for the cycle in which they are sampled.
 */
`timescale 1ns/1ps
module sfcc_mul #(
    parameter W    = 32,
    parameter FRAC = 13
) (
    input  wire                clk_i,
    input  wire                rst_i,
    input  wire signed [W-1:0] a_i,
    input  wire signed [W-1:0] b_i,
    output reg  signed [W-1:0] p_o
);
    wire signed [2*W-1:0] full_prod;
    wire signed [2*W-1:0] shifted;

    assign full_prod = a_i * b_i;
    assign shifted   = full_prod >>> FRAC;

    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            p_o <= {W{1'b0}};
        end else begin
            p_o <= shifted[W-1:0];
        end
    end
endmodule // sfcc_mul

// *** rtl/sfcc_sat.v ***
/*
 * Signed saturating adder for current setpoint correction.
 * Assumes two's complement operands of equal width.
 */
`timescale 1ns/1ps
module sfcc_sat #(
    parameter W = 32
) (
    input  wire signed [W-1:0] a_i,
    input  wire signed [W-1:0] b_i,
    output reg  signed [W-1:0] s_o
);
    wire signed [W:0] sum;

    assign sum = {a_i[W-1], a_i} + {b_i[W-1], b_i};

    // Wrap-around would flip the torque sign, so clamp instead
    always @* begin
        if (sum[W] != sum[W-1]) begin
            s_o = sum[W] ? {1'b1, {(W-1){1'b0}}} : {1'b0, {(W-1){1'b1}}};
        end else begin
            s_o = sum[W-1:0];
        end
    end
endmodule // sfcc_sat

// *** rtl/sfcc_top.v ***
/*
 * Motor output filter current compensation: computes motor terminal
 * voltage and filter capacitor current from d/q setpoints, adds the
 * capacitor current in sine filter mode and drives the decoupling
 * enable of the current controller. Registers over AHB-Lite.
 * Assumes SAMPLE_I pulses once per current control sample, at least
 * seven cycles apart, with setpoints valid on the pulse.
 */
// Functional notes
// - Selector 0: no compensation, decoupling active
// - Selector 1: setpoints pass unchanged
// - Selector 1: decoupling disabled
// - Selector 1: motor voltages still computed, visible
// - Selector 2: add capacitor currents to setpoints
// - Selector 2: decoupling disabled
// - Cap current: -/+ 2pi f C motor voltage
// - Motor voltage from f, L, setpoints, flux
// - Configured capacitance times 3 per phase
// - Capacitance setting in nF, delta, index 1
// - Selector 2: voltages and cap currents visible
`timescale 1ns/1ps
`include "sfcc_defs.vh"
module sfcc_top #(
    parameter W = 32
) (
    input  wire         SYS_CLK_I,
    input  wire         SYS_RST_I,
    input  wire         HSEL_I,
    input  wire [31:0]  HADDR_I,
    input  wire [1:0]   HTRANS_I,
    input  wire         HWRITE_I,
    input  wire [2:0]   HSIZE_I,
    input  wire [31:0]  HWDATA_I,
    input  wire         HREADY_I,
    output reg  [31:0]  HRDATA_O,
    output wire         HREADYOUT_O,
    output wire         HRESP_O,
    input  wire         SAMPLE_I,
    input  wire [W-1:0] ID_REF_I,
    input  wire [W-1:0] IQ_REF_I,
    input  wire [W-1:0] STATOR_FREQ_I,
    output reg  [W-1:0] ID_REF_O,
    output reg  [W-1:0] IQ_REF_O,
    output reg          DECOUPLE_EN_O,
    output reg  [W-1:0] MOTOR_D_VOLTAGE_CALC_O,
    output reg  [W-1:0] MOTOR_Q_VOLTAGE_CALC_O,
    output reg  [W-1:0] CAP_D_CURRENT_CALC_O,
    output reg  [W-1:0] CAP_Q_CURRENT_CALC_O,
    output reg          RESULT_VALID_O
);
    // ****************************************************************
    // AHB-Lite slave
    // ****************************************************************
    reg [1:0]   filter_sel_q;
    reg [W-1:0] ls_q;
    reg [W-1:0] flux_q;
    reg [W-1:0] cfilt_q;
    reg [W-1:0] lfilt_q;
    reg [31:0]  samples_q;
    reg         wr_pend_q;
    reg [7:0]   wr_addr_q;
    wire        busy;
    wire        choke_mode;
    wire        sine_filter_mode;
    wire        acc;

    assign acc         = HSEL_I && HREADY_I && HTRANS_I[1];
    assign HREADYOUT_O = 1'b1;
    assign HRESP_O     = 1'b0;

    always @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
        end else begin
            wr_pend_q <= acc && HWRITE_I;
            wr_addr_q <= HADDR_I[7:0];
        end
    end

    // Filter parameter set: index 0 choke inductance, index 1 capacitance in nF (delta)
    always @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            filter_sel_q <= `SFCC_RST_SEL;
            ls_q         <= {W{1'b0}};
            flux_q       <= {W{1'b0}};
            cfilt_q      <= {W{1'b0}};
            lfilt_q      <= {W{1'b0}};
        end else if (wr_pend_q) begin
            case (wr_addr_q)
                `SFCC_OFS_CTRL: begin
                    filter_sel_q <= HWDATA_I[`SFCC_CTRL_SEL_MSB:`SFCC_CTRL_SEL_LSB];
                end
                `SFCC_OFS_LS: begin
                    ls_q <= HWDATA_I[W-1:0];
                end
                `SFCC_OFS_FLUX: begin
                    flux_q <= HWDATA_I[W-1:0];
                end
                `SFCC_OFS_CFILT: begin
                    cfilt_q <= HWDATA_I[W-1:0];
                end
                `SFCC_OFS_LFILT: begin
                    lfilt_q <= HWDATA_I[W-1:0];
                end
                default: begin
                    filter_sel_q <= filter_sel_q;
                end
            endcase
        end
    end

    assign choke_mode       = (filter_sel_q == `SFCC_SEL_CHOKE);
    assign sine_filter_mode = (filter_sel_q == `SFCC_SEL_SINE);

    // ****************************************************************
    // Compute pipeline: five multiply steps per sample
    // ****************************************************************
    localparam ST_IDLE = 2'd0;
    localparam ST_VOLT = 2'd1;
    localparam ST_CAP  = 2'd2;
    localparam ST_DONE = 2'd3;

    reg  [1:0]   state_q;
    reg  [1:0]   state_d;
    reg  [2:0]   cnt_q;
    reg  [W-1:0] w_q;
    reg  [W-1:0] id_s_q;
    reg  [W-1:0] iq_s_q;
    reg  [W-1:0] ud_q;
    reg  [W-1:0] uq_q;
    reg  [W-1:0] icd_q;
    reg  [W-1:0] icq_q;
    reg  [W-1:0] ma_a;
    reg  [W-1:0] ma_b;
    reg  [W-1:0] mb_a;
    reg  [W-1:0] mb_b;
    wire [W-1:0] ma_p;
    wire [W-1:0] mb_p;
    wire [W-1:0] id_sum;
    wire [W-1:0] iq_sum;
    wire [W-1:0] c_phase;

    assign busy    = (state_q != ST_IDLE);
    assign c_phase = cfilt_q * {{(W-18){1'b0}}, `SFCC_DELTA_FACTOR};

    sfcc_mul #(.W(W), .FRAC(`SFCC_FRAC_BITS)) u_mul_a (
        .clk_i (SYS_CLK_I),
        .rst_i (SYS_RST_I),
        .a_i   (ma_a),
        .b_i   (ma_b),
        .p_o   (ma_p)
    );

    sfcc_mul #(.W(W), .FRAC(`SFCC_FRAC_BITS)) u_mul_b (
        .clk_i (SYS_CLK_I),
        .rst_i (SYS_RST_I),
        .a_i   (mb_a),
        .b_i   (mb_b),
        .p_o   (mb_p)
    );

    // Operand routing per sub-step: cnt 0 forms w=2pi f, 1 forms L*i,
    // 2 forms voltages, 3 forms w*C, 4 forms capacitor currents
    always @* begin
        ma_a = {W{1'b0}};
        ma_b = {W{1'b0}};
        mb_a = {W{1'b0}};
        mb_b = {W{1'b0}};
        case (cnt_q)
            3'd0: begin
                ma_a = {{(W-16){1'b0}}, `SFCC_TWO_PI_Q13};
                ma_b = STATOR_FREQ_I;
            end
            3'd1: begin
                ma_a = ls_q;
                ma_b = iq_s_q;
                mb_a = ls_q;
                mb_b = id_s_q;
            end
            3'd2: begin
                ma_a = w_q;
                ma_b = ma_p;
                mb_a = w_q;
                mb_b = mb_p + flux_q;
            end
            3'd3: begin
                ma_a = w_q;
                ma_b = c_phase;
            end
            3'd4: begin
                ma_a = ma_p;
                ma_b = uq_q;
                mb_a = ma_p;
                mb_b = ud_q;
            end
            default: begin
                ma_a = {W{1'b0}};
            end
        endcase
    end

    always @* begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (SAMPLE_I) begin
                    state_d = ST_VOLT;
                end
            end
            ST_VOLT: begin
                if (cnt_q == 3'd3) begin
                    state_d = ST_CAP;
                end
            end
            ST_CAP: begin
                if (cnt_q == 3'd5) begin
                    state_d = ST_DONE;
                end
            end
            ST_DONE: begin
                state_d = ST_IDLE;
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    // Products land one cycle after their operands, hence cnt-1 capture
    always @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            state_q <= ST_IDLE;
            cnt_q   <= 3'd0;
            w_q     <= {W{1'b0}};
            id_s_q  <= {W{1'b0}};
            iq_s_q  <= {W{1'b0}};
            ud_q    <= {W{1'b0}};
            uq_q    <= {W{1'b0}};
            icd_q   <= {W{1'b0}};
            icq_q   <= {W{1'b0}};
        end else begin
            state_q <= state_d;
            if (state_q == ST_IDLE) begin
                cnt_q <= 3'd0;
                if (SAMPLE_I) begin
                    id_s_q <= ID_REF_I;
                    iq_s_q <= IQ_REF_I;
                    cnt_q  <= 3'd1;
                end
            end else begin
                cnt_q <= (state_q == ST_DONE) ? 3'h0 : cnt_q + 3'h1;
            end
            case (cnt_q)
                3'd1: begin
                    w_q <= ma_p;
                end
                3'd3: begin
                    ud_q <= {W{1'b0}} - ma_p;
                    uq_q <= mb_p;
                end
                3'd5: begin
                    icd_q <= {W{1'b0}} - ma_p;
                    icq_q <= mb_p;
                end
                default: begin
                    w_q <= w_q;
                end
            endcase
        end
    end

    // ****************************************************************
    // Setpoint correction and outputs
    // ****************************************************************
    sfcc_sat #(.W(W)) u_sat_d (
        .a_i (id_s_q),
        .b_i (icd_q),
        .s_o (id_sum)
    );

    sfcc_sat #(.W(W)) u_sat_q (
        .a_i (iq_s_q),
        .b_i (icq_q),
        .s_o (iq_sum)
    );

    always @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            ID_REF_O               <= {W{1'b0}};
            IQ_REF_O               <= {W{1'b0}};
            DECOUPLE_EN_O          <= 1'b1;
            MOTOR_D_VOLTAGE_CALC_O <= {W{1'b0}};
            MOTOR_Q_VOLTAGE_CALC_O <= {W{1'b0}};
            CAP_D_CURRENT_CALC_O   <= {W{1'b0}};
            CAP_Q_CURRENT_CALC_O   <= {W{1'b0}};
            RESULT_VALID_O         <= 1'b0;
            samples_q              <= `SFCC_RST_WORD;
        end else begin
            DECOUPLE_EN_O  <= !(choke_mode || sine_filter_mode);
            RESULT_VALID_O <= (state_q == ST_DONE);
            if (state_q == ST_DONE) begin
                samples_q              <= samples_q + 32'h00000001;
                MOTOR_D_VOLTAGE_CALC_O <= ud_q;
                MOTOR_Q_VOLTAGE_CALC_O <= uq_q;
                CAP_D_CURRENT_CALC_O   <= icd_q;
                CAP_Q_CURRENT_CALC_O   <= icq_q;
                if (sine_filter_mode) begin
                    ID_REF_O <= id_sum;
                    IQ_REF_O <= iq_sum;
                end else begin
                    ID_REF_O <= id_s_q;
                    IQ_REF_O <= iq_s_q;
                end
            end
        end
    end

    // ****************************************************************
    // Read data: registered in the data phase, unmapped reads zero
    // ****************************************************************
    always @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            HRDATA_O <= 32'h00000000;
        end else if (acc && !HWRITE_I) begin
            case (HADDR_I[7:0])
                `SFCC_OFS_CTRL:    HRDATA_O <= {30'h00000000, filter_sel_q};
                `SFCC_OFS_FREQ:    HRDATA_O <= STATOR_FREQ_I;
                `SFCC_OFS_IDREF:   HRDATA_O <= ID_REF_I;
                `SFCC_OFS_IQREF:   HRDATA_O <= IQ_REF_I;
                `SFCC_OFS_LS:      HRDATA_O <= ls_q;
                `SFCC_OFS_FLUX:    HRDATA_O <= flux_q;
                `SFCC_OFS_CFILT:   HRDATA_O <= cfilt_q;
                `SFCC_OFS_LFILT:   HRDATA_O <= lfilt_q;
                `SFCC_OFS_STATUS:  HRDATA_O <= {28'h0000000, busy, DECOUPLE_EN_O, filter_sel_q};
                `SFCC_OFS_UD:      HRDATA_O <= MOTOR_D_VOLTAGE_CALC_O;
                `SFCC_OFS_UQ:      HRDATA_O <= MOTOR_Q_VOLTAGE_CALC_O;
                `SFCC_OFS_ICD:     HRDATA_O <= CAP_D_CURRENT_CALC_O;
                `SFCC_OFS_ICQ:     HRDATA_O <= CAP_Q_CURRENT_CALC_O;
                `SFCC_OFS_IDOUT:   HRDATA_O <= ID_REF_O;
                `SFCC_OFS_IQOUT:   HRDATA_O <= IQ_REF_O;
                `SFCC_OFS_SAMPLES: HRDATA_O <= samples_q;
                default:           HRDATA_O <= 32'h00000000;
            endcase
        end
    end
endmodule // sfcc_top

// *** verif/sfcc_ctl_model.sv ***
/*
 * Model of the current controller feeding one control sample at a time.
 * Assumes the block answers six cycles after the sample edge.
 */
`timescale 1ns/1ps
module sfcc_ctl_model (
    input  wire         clk_i,
    input  wire         res_valid_i,
    output logic        sample_o,
    output logic [31:0] id_o,
    output logic [31:0] iq_o,
    output logic [31:0] freq_o
);
initial begin
    sample_o = 1'b0;
    id_o     = 32'h0;
    iq_o     = 32'h0;
    freq_o   = 32'h0;
end
// Inputs are scrambled after the sample edge, so stale use shows up
task automatic send(input logic [31:0] id, input logic [31:0] iq, input logic [31:0] f, output logic got);
    @(posedge clk_i);
    sample_o <= 1'b1;
    id_o     <= id;
    iq_o     <= iq;
    freq_o   <= f;
    @(posedge clk_i);
    sample_o <= 1'b0;
    id_o     <= ~id;
    iq_o     <= ~iq;
    freq_o   <= ~f;
    repeat (6) @(posedge clk_i);
    #1;
    got = res_valid_i;
endtask
endmodule // sfcc_ctl_model

// *** verif/sfcc_props.sv ***
/*
 * Checker for the filter current compensation top: timing of results,
 * decoupling against the selector, setpoint pass and correction.
 * Assumes it is bound to the top, one clock, async active-high reset.
 */
`timescale 1ns/1ps
module sfcc_props #(
    parameter W = 32
) (
    input wire         SYS_CLK_I,
    input wire         SYS_RST_I,
    input wire         HSEL_I,
    input wire [31:0]  HADDR_I,
    input wire [1:0]   HTRANS_I,
    input wire         HWRITE_I,
    input wire [31:0]  HWDATA_I,
    input wire         HREADY_I,
    input wire         SAMPLE_I,
    input wire [W-1:0] ID_REF_I,
    input wire [W-1:0] IQ_REF_I,
    input wire [W-1:0] STATOR_FREQ_I,
    input wire [W-1:0] ID_REF_O,
    input wire [W-1:0] IQ_REF_O,
    input wire         DECOUPLE_EN_O,
    input wire [W-1:0] MOTOR_D_VOLTAGE_CALC_O,
    input wire [W-1:0] MOTOR_Q_VOLTAGE_CALC_O,
    input wire [W-1:0] CAP_D_CURRENT_CALC_O,
    input wire [W-1:0] CAP_Q_CURRENT_CALC_O,
    input wire         RESULT_VALID_O
);
// ****************************************************************
// Selector shadow, taken from bus writes to the control word
// ****************************************************************
logic       wr_ctrl_q;
logic [1:0] sel_q;
always @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
        wr_ctrl_q <= 1'b0;
        sel_q     <= 2'h0;
    end else begin
        wr_ctrl_q <= HSEL_I && HREADY_I && HTRANS_I[1] && HWRITE_I && (HADDR_I[7:0] == 8'h00);
        if (wr_ctrl_q) begin
            sel_q <= HWDATA_I[1:0];
        end
    end
end
default clocking @(posedge SYS_CLK_I); endclocking
default disable iff (SYS_RST_I);
// ****************************************************************
// Properties
// ****************************************************************
chk_valid_latency: assert property (RESULT_VALID_O |-> $past(SAMPLE_I, 7))
    else $error("result without sample seven cycles before");
chk_valid_single: assert property (RESULT_VALID_O |=> !RESULT_VALID_O)
    else $error("result pulse longer than one cycle");
chk_decouple_sel: assert property ($stable(sel_q) && sel_q == $past(sel_q, 2)
    |-> DECOUPLE_EN_O == (sel_q == 2'h0 || sel_q == 2'h3))
    else $error("decoupling enable does not follow selector");
chk_pass_setpoint: assert property (RESULT_VALID_O && sel_q != 2'h2
    |-> ID_REF_O == $past(ID_REF_I, 7) && IQ_REF_O == $past(IQ_REF_I, 7))
    else $error("setpoints altered outside sine filter mode");
chk_sine_add: assert property (RESULT_VALID_O && sel_q == 2'h2
    |-> ID_REF_O == $past(ID_REF_I, 7) + CAP_D_CURRENT_CALC_O && IQ_REF_O == $past(IQ_REF_I, 7) + CAP_Q_CURRENT_CALC_O)
    else $error("capacitor current not added to setpoints");
chk_results_hold: assert property (!RESULT_VALID_O |-> $stable(MOTOR_D_VOLTAGE_CALC_O)
    && $stable(MOTOR_Q_VOLTAGE_CALC_O) && $stable(CAP_D_CURRENT_CALC_O) && $stable(CAP_Q_CURRENT_CALC_O))
    else $error("observed results changed without a result pulse");
chk_zero_freq: assert property (RESULT_VALID_O && $past(STATOR_FREQ_I, 7) == 0
    |-> MOTOR_D_VOLTAGE_CALC_O == 0 && MOTOR_Q_VOLTAGE_CALC_O == 0)
    else $error("motor voltage not zero at zero frequency");
chk_cap_from_volt: assert property (RESULT_VALID_O ##1 MOTOR_D_VOLTAGE_CALC_O == 0
    && MOTOR_Q_VOLTAGE_CALC_O == 0 |-> CAP_D_CURRENT_CALC_O == 0 && CAP_Q_CURRENT_CALC_O == 0)
    else $error("capacitor current without motor voltage");
cov_sine: cover property (RESULT_VALID_O && sel_q == 2'h2);
cov_choke: cover property (RESULT_VALID_O && sel_q == 2'h1);
cov_zero: cover property (RESULT_VALID_O && $past(STATOR_FREQ_I, 7) == 0);
endmodule // sfcc_props

// *** verif/tb_sfcc_top.sv ***
/*
 * Testbench for the filter compensation top: registers over AHB-Lite,
 * one sample per selector code, a zero frequency sample.
 * Assumes the controller model and the checker are compiled with it.
 */
`timescale 1ns/1ps
module tb_sfcc_top;
logic        clk = 1'b0;
logic        rst = 1'b1;
logic        hsel = 1'b0;
logic        hwrite = 1'b0;
logic [1:0]  htrans = 2'h0;
logic [31:0] haddr = 32'h0;
logic [31:0] hwdata = 32'h0;
wire  [31:0] hrdata, id_o, iq_o, ud_o, uq_o, icd_o, icq_o, id_i, iq_i, f_i;
wire         hready, hresp, dec_o, valid_o, smp;
int          n_mismatch = 0;
int          n_tests = 0;
int          cycles = 0;
always #2 clk = ~clk;
sfcc_top i_sfcc_top (.SYS_CLK_I(clk), .SYS_RST_I(rst), .HSEL_I(hsel), .HADDR_I(haddr), .HTRANS_I(htrans),
    .HWRITE_I(hwrite), .HSIZE_I(3'h2), .HWDATA_I(hwdata), .HREADY_I(hready), .HRDATA_O(hrdata),
    .HREADYOUT_O(hready), .HRESP_O(hresp), .SAMPLE_I(smp), .ID_REF_I(id_i), .IQ_REF_I(iq_i),
    .STATOR_FREQ_I(f_i), .ID_REF_O(id_o), .IQ_REF_O(iq_o), .DECOUPLE_EN_O(dec_o),
    .MOTOR_D_VOLTAGE_CALC_O(ud_o), .MOTOR_Q_VOLTAGE_CALC_O(uq_o), .CAP_D_CURRENT_CALC_O(icd_o),
    .CAP_Q_CURRENT_CALC_O(icq_o), .RESULT_VALID_O(valid_o));
sfcc_ctl_model i_sfcc_ctl_model (.clk_i(clk), .res_valid_i(valid_o), .sample_o(smp), .id_o(id_i),
    .iq_o(iq_i), .freq_o(f_i));
// ****************************************************************
// Tasks
// ****************************************************************
task stop_test;
    if (n_mismatch == 0 && n_tests > 0)
        $display("All tests passed");
    else
        $display("Some tests failed");
    $finish;
endtask
task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
        n_mismatch++;
        $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
endtask
task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr  <= {24'h0, a};
    do @(posedge clk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
endtask
function automatic longint mq(longint a, longint b);
    return (a * b) >>> 13;
endfunction
// Ceiling well above the roughly 110 cycles the sequence needs
always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
        n_mismatch++;
        stop_test;
    end
end
// ****************************************************************
// Sequence
// ****************************************************************
initial begin
    logic [31:0] rd, prm [3];
    logic        got;
    longint      w, ud, uq, wc, icd, icq;
    // Frequency chosen so every fixed-point product is exact
    longint      id = 64'h2000, iq = 64'h4000, f = 64'h400000;
    prm = '{32'h20, 32'h10, 32'h2000};
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    chk("decouple_reset", {31'h0, dec_o}, 32'h1);
    for (int i = 0; i < 3; i++) begin
        ahb(1'b1, 8'h10 + 8'(4 * i), prm[i], rd);
        ahb(1'b0, 8'h10 + 8'(4 * i), 32'h0, rd);
        chk("param", rd, prm[i]);
    end
    ahb(1'b0, 8'h40, 32'h0, rd);
    chk("unmapped", rd, 32'h0);
    chk("hresp", {31'h0, hresp}, 32'h0);
    w   = mq(64'hC910, f);
    ud  = -mq(w, mq(prm[0], iq));
    uq  = mq(w, mq(prm[0], id) + prm[1]);
    wc  = mq(w, 3 * prm[2]);
    icd = -mq(wc, uq);
    icq = mq(wc, ud);
    for (int s = 0; s < 4; s++) begin
        ahb(1'b1, 8'h00, 32'(s), rd);
        i_sfcc_ctl_model.send(32'(id), 32'(iq), 32'(f), got);
        chk("valid", {31'h0, got}, 32'h1);
        chk("decouple", {31'h0, dec_o}, 32'(s == 0 || s == 3));
        chk("id_out", id_o, 32'(s == 2 ? id + icd : id));
        chk("iq_out", iq_o, 32'(s == 2 ? iq + icq : iq));
        chk("ud", ud_o, 32'(ud));
        chk("uq", uq_o, 32'(uq));
        chk("icd", icd_o, 32'(icd));
        chk("icq", icq_o, 32'(icq));
        ahb(1'b0, 8'h20, 32'h0, rd);
        chk("status", rd, {29'h0, s == 0 || s == 3, 2'(s)});
    end
    ahb(1'b0, 8'h24, 32'h0, rd);
    chk("ud_reg", rd, 32'(ud));
    ahb(1'b1, 8'h04, 32'hFFFFFFFF, rd);
    ahb(1'b0, 8'h04, 32'h0, rd);
    chk("freq_reg", rd, 32'(~f));
    ahb(1'b1, 8'h00, 32'h2, rd);
    i_sfcc_ctl_model.send(32'(id), 32'(iq), 32'h0, got);
    chk("ud_zero", ud_o, 32'h0);
    chk("icd_zero", icd_o, 32'h0);
    chk("id_zero", id_o, 32'(id));
    ahb(1'b0, 8'h3C, 32'h0, rd);
    chk("samples", rd, 32'h5);
    stop_test;
end
endmodule // tb_sfcc_top
bind sfcc_top sfcc_props #(.W(W)) i_sfcc_props (.SYS_CLK_I, .SYS_RST_I, .HSEL_I, .HADDR_I, .HTRANS_I,
    .HWRITE_I, .HWDATA_I, .HREADY_I, .SAMPLE_I, .ID_REF_I, .IQ_REF_I, .STATOR_FREQ_I, .ID_REF_O,
    .IQ_REF_O, .DECOUPLE_EN_O, .MOTOR_D_VOLTAGE_CALC_O, .MOTOR_Q_VOLTAGE_CALC_O, .CAP_D_CURRENT_CALC_O,
    .CAP_Q_CURRENT_CALC_O, .RESULT_VALID_O);
